// ==== include/gwel_pkg.sv ====
// Constants, register map and state layout of the general pin, wake event and LED block.
// Assumes one 100 MHz mclk and a byte-wide runtime register port driven by the host bus logic.
package gwel_pkg;
  localparam int NUM_PINS  = 64;
  localparam int NUM_GROUPS = 8;
  localparam int WAKE_BANKS = 6;
  localparam int SMI_BANKS = 5;
  localparam int EE_PINS   = 6;
  localparam int LED_N     = 2;

  localparam logic [6:0] OFS_CFG      = 7'h00;
  localparam logic [6:0] OFS_DATA     = 7'h40;
  localparam logic [6:0] OFS_WAKE_STS = 7'h48;
  localparam logic [6:0] OFS_WAKE_EN  = 7'h50;
  localparam logic [6:0] OFS_GWAKE    = 7'h58;
  localparam logic [6:0] OFS_MISC     = 7'h59;
  localparam logic [6:0] OFS_LED_ONE  = 7'h5d;
  localparam logic [6:0] OFS_LED_TWO  = 7'h5e;
  localparam logic [6:0] OFS_SMI_STS  = 7'h60;
  localparam logic [6:0] OFS_SMI_EN   = 7'h68;
  localparam logic [6:0] CNT_DATA     = 7'h08;
  localparam logic [6:0] CNT_WAKE     = 7'h06;
  localparam logic [6:0] CNT_SMI      = 7'h05;

  localparam int CFG_DIR = 0;
  localparam int CFG_POL = 1;
  localparam int CFG_EE  = 2;
  localparam int CFG_OD  = 7;
  localparam int LED_ON_BIT    = 0;
  localparam int LED_BLINK_BIT = 1;
  localparam int LED_EN_BIT    = 7;
  localparam int GWAKE_BIT     = 0;
  localparam logic [7:0] CFG_RST_IN  = 8'h01;
  localparam logic [7:0] CFG_RST_OUT = 8'h00;

  localparam logic [6:0] PIN_G3P3 = 7'h13;
  localparam logic [6:0] PIN_G4P3 = 7'h1b;
  localparam logic [6:0] PIN_G5P3 = 7'h23;
  localparam logic [6:0] LED_PIN [0:1] = '{7'h28, 7'h29};
  localparam int SRC_NONE_BIT = 6;
  localparam logic [6:0] NO = 7'h40;
  localparam int SMI_SHARED_BANK = 2;
  localparam logic [6:0] EE_PIN [0:5] = '{7'h09, 7'h0a, 7'h19, 7'h1b, 7'h28, 7'h29};

  localparam logic [6:0] WAKE_SRC [0:5][0:7] = '{
    '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h07},
    '{7'h08, 7'h09, 7'h0a, 7'h0b, 7'h0c, 7'h0d, 7'h0e, 7'h0f},
    '{7'h10, 7'h11, 7'h12, 7'h13, 7'h19, 7'h1b, 7'h28, 7'h29},
    '{7'h20, 7'h21, 7'h22, 7'h23, 7'h24, 7'h25, 7'h26, 7'h27},
    '{NO, NO, NO, NO, NO, NO, NO, NO},
    '{7'h14, 7'h15, 7'h16, 7'h17, 7'h2a, NO, NO, NO}};
  localparam logic [6:0] SMI_SRC [0:4][0:7] = '{
    '{7'h08, 7'h09, 7'h0a, 7'h28, 7'h0c, 7'h0d, 7'h0e, 7'h0f},
    '{7'h10, 7'h11, 7'h12, 7'h13, 7'h19, 7'h1b, 7'h29, NO},
    '{7'h20, 7'h21, 7'h22, 7'h23, 7'h24, 7'h25, 7'h26, 7'h27},
    '{NO, NO, NO, NO, NO, NO, NO, NO},
    '{7'h14, 7'h15, 7'h16, 7'h17, 7'h2a, NO, NO, NO}};

  localparam int CLK32_HZ      = 32768;
  localparam int BLINK_HALF_MS = 500;
  localparam int BLINK_HALF    = CLK32_HZ * BLINK_HALF_MS / 1000;
  localparam int BLINK_W       = 16;

  typedef struct packed {
    logic [63:0][7:0] cfg;
    logic [63:0]      dout;
    logic [63:0]      sync_a;
    logic [63:0]      sync_b;
    logic [63:0]      prev;
    logic [5:0][7:0]  wake_sts;
    logic [5:0][7:0]  wake_en;
    logic [7:0]       gwake;
    logic [4:0][7:0]  smi_sts;
    logic [4:0][7:0]  smi_en;
    logic [5:0]       misc_sts;
    logic [1:0][7:0]  led;
    logic             c32_a;
    logic             c32_b;
    logic             c32_prev;
    logic [15:0]      blink_cnt;
    logic             blink;
    logic [7:0]       rdata;
    logic             wake;
    logic             smi;
  } gwel_state_s;
endpackage

// ==== hw/gwel_gpio.sv ====
// General pin logic with wake and system-management events and two LED drivers.
// Assumes pin inputs, power and reset strobes are synchronous to mclk; clk32 is sampled.
// How it works
// - Input bits read back the synchronised pin level, optionally inverted by polarity.
// - Writes to input bits change neither the pin nor the value read.
// - Output bits drive the stored data value, inverted when polarity says so.
// - Output bits read back the last written data value.
// - Polarity picks the edge that sets wake status; rising by default.
// - Wake output needs status, per-pin enable and global enable together.
// - Wake status bits clear on a written one; zero leaves them.
// - Wake banks two to seven map pins per the fixed source table.
// - SMI banks three to seven map pins per the fixed source table.
// - Group four bit zero and groups seven, eight have no event path.
// - Six either-edge pins set wake and SMI status on both edges.
// - In either-edge mode direction does nothing, polarity picks no edge, and driver type only applies to an enabled LED.
// - In either-edge mode polarity still inverts the data read.
// - Either-edge pins raise interrupts only when the mode and enable are set.
// - Misc status holds one bit per either-edge pin, set each edge, one-clear.
// - Status bits record events whether enabled or in either-edge mode.
// - Two LED pins switch on, off or blinking by registers 0x5D, 0x5E.
// - LEDs work without main power; blinking needs the 32 kHz clock running.
// - Group three pin three comes up low output; plain output without main power.
// - Group five pin three comes up low output after every reset and without power.
// - Group four pin three returns to plain function after main or bus reset.
// - Configuration holds direction bit 0, polarity bit 1, driver type bit 7.
// - Direction 0 is output, 1 input; polarity 0 plain, 1 inverted.
module gwel_gpio #(
  parameter int BLINK_HALF = gwel_pkg::BLINK_HALF
) (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        main_rst,
  input  wire logic        bus_rst,
  input  wire logic        main_pwr_ok,
  input  wire logic        clk32_in,
  input  wire logic [6:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic [63:0] pin_in,
  output logic      [63:0] pin_out,
  output logic      [63:0] pin_oe,
  output logic             wake_event,
  output logic             smi_event
);
  gwel_pkg::gwel_state_s st_q;
  gwel_pkg::gwel_state_s st_d;

  logic [63:0]     rise;
  logic [63:0]     fall;
  logic [63:0]     ev;
  logic [63:0]     is_in;
  logic [63:0]     ee_mode;
  logic [63:0]     qual;
  logic [7:0][7:0] data_rd;
  logic [7:0]      rd_val;
  logic [7:0]      w1c;
  logic [2:0]      bank;
  logic [6:0]      src;
  logic            set_b;
  logic            q_b;
  logic            wake_any;
  logic            smi_any;
  logic            lvl;
  logic            led_lvl;

  // Per-pin decode of mode, edges and read value.
  always_comb begin
    for (int i = 0; i < gwel_pkg::NUM_PINS; i++) begin
      ee_mode[i] = 1'b0;
      for (int k = 0; k < gwel_pkg::EE_PINS; k++) begin
        if (gwel_pkg::EE_PIN[k] == 7'(i)) begin
          ee_mode[i] = st_q.cfg[i][gwel_pkg::CFG_EE];
        end
      end
      rise[i] = st_q.sync_b[i] & ~st_q.prev[i];
      fall[i] = ~st_q.sync_b[i] & st_q.prev[i];
      // Either-edge mode catches both edges, otherwise polarity selects one.
      if (ee_mode[i]) begin
        ev[i] = rise[i] | fall[i];
      end else if (st_q.cfg[i][gwel_pkg::CFG_POL]) begin
        ev[i] = fall[i];
      end else begin
        ev[i] = rise[i];
      end
      // Direction 1 is input; either-edge mode overrides direction.
      is_in[i] = st_q.cfg[i][gwel_pkg::CFG_DIR] | ee_mode[i];
      // Either-edge pins only count toward the outputs while in that mode.
      qual[i] = 1'b1;
      for (int k = 0; k < gwel_pkg::EE_PINS; k++) begin
        if (gwel_pkg::EE_PIN[k] == 7'(i)) begin
          qual[i] = ee_mode[i];
        end
      end
      // Inputs read the sampled level through polarity.
      data_rd[i / 8][i % 8] = is_in[i] ? (st_q.sync_b[i] ^ st_q.cfg[i][gwel_pkg::CFG_POL])
                                       : st_q.dout[i];
    end
  end

  // Pin drivers, including LED and loss-of-main-power overrides.
  always_comb begin
    led_lvl = 1'b0;
    for (int i = 0; i < gwel_pkg::NUM_PINS; i++) begin
      // Output value is data through polarity.
      lvl = st_q.dout[i] ^ st_q.cfg[i][gwel_pkg::CFG_POL];
      pin_out[i] = lvl;
      pin_oe[i] = ~is_in[i];
      // Open drain only ever pulls low.
      if (st_q.cfg[i][gwel_pkg::CFG_OD] && !ee_mode[i]) begin
        pin_out[i] = 1'b0;
        pin_oe[i] = ~is_in[i] & ~lvl;
      end
      for (int k = 0; k < gwel_pkg::LED_N; k++) begin
        if (gwel_pkg::LED_PIN[k] == 7'(i) && st_q.led[k][gwel_pkg::LED_EN_BIT]) begin
          // Blink follows the divided 32 kHz clock and freezes if it stops.
          led_lvl = st_q.led[k][gwel_pkg::LED_BLINK_BIT] ? st_q.blink
                                                         : st_q.led[k][gwel_pkg::LED_ON_BIT];
          if (st_q.cfg[i][gwel_pkg::CFG_OD]) begin
            pin_out[i] = 1'b0;
            pin_oe[i] = led_lvl;
          end else begin
            pin_out[i] = led_lvl;
            pin_oe[i] = 1'b1;
          end
        end
      end
      if (!main_pwr_ok && 7'(i) == gwel_pkg::PIN_G3P3) begin
        pin_out[i] = st_q.dout[i];
        pin_oe[i] = 1'b1;
      end
      if (!main_pwr_ok && 7'(i) == gwel_pkg::PIN_G5P3) begin
        pin_out[i] = 1'b0;
        pin_oe[i] = 1'b1;
      end
    end
  end

  // Register read decode.
  always_comb begin
    rd_val = 8'h00;
    if (reg_addr < gwel_pkg::OFS_DATA) begin
      rd_val = st_q.cfg[reg_addr[5:0]];
    end else if (reg_addr < gwel_pkg::OFS_DATA + gwel_pkg::CNT_DATA) begin
      rd_val = data_rd[reg_addr[2:0]];
    end else if (reg_addr >= gwel_pkg::OFS_WAKE_STS &&
                 reg_addr < gwel_pkg::OFS_WAKE_STS + gwel_pkg::CNT_WAKE) begin
      rd_val = st_q.wake_sts[3'(reg_addr - gwel_pkg::OFS_WAKE_STS)];
    end else if (reg_addr >= gwel_pkg::OFS_WAKE_EN &&
                 reg_addr < gwel_pkg::OFS_WAKE_EN + gwel_pkg::CNT_WAKE) begin
      rd_val = st_q.wake_en[3'(reg_addr - gwel_pkg::OFS_WAKE_EN)];
    end else if (reg_addr == gwel_pkg::OFS_GWAKE) begin
      rd_val = st_q.gwake;
    end else if (reg_addr == gwel_pkg::OFS_MISC) begin
      rd_val = {2'h0, st_q.misc_sts};
    end else if (reg_addr == gwel_pkg::OFS_LED_ONE) begin
      rd_val = st_q.led[0];
    end else if (reg_addr == gwel_pkg::OFS_LED_TWO) begin
      rd_val = st_q.led[1];
    end else if (reg_addr >= gwel_pkg::OFS_SMI_STS &&
                 reg_addr < gwel_pkg::OFS_SMI_STS + gwel_pkg::CNT_SMI) begin
      rd_val = st_q.smi_sts[3'(reg_addr - gwel_pkg::OFS_SMI_STS)];
    end else if (reg_addr >= gwel_pkg::OFS_SMI_EN &&
                 reg_addr < gwel_pkg::OFS_SMI_EN + gwel_pkg::CNT_SMI) begin
      rd_val = st_q.smi_en[3'(reg_addr - gwel_pkg::OFS_SMI_EN)];
    end
  end

  // Next state.
  always_comb begin
    st_d = st_q;
    w1c = 8'h00;
    bank = 3'h0;
    src = 7'h00;
    set_b = 1'b0;
    q_b = 1'b0;
    wake_any = 1'b0;
    smi_any = 1'b0;
    // Two-stage capture; only sync_b feeds the edge logic.
    st_d.sync_a = pin_in;
    st_d.sync_b = st_q.sync_a;
    st_d.prev = st_q.sync_b;
    st_d.c32_a = clk32_in;
    st_d.c32_b = st_q.c32_a;
    st_d.c32_prev = st_q.c32_b;
    if (st_q.c32_b && !st_q.c32_prev) begin
      if (st_q.blink_cnt == 16'(BLINK_HALF - 1)) begin
        st_d.blink_cnt = 16'h0000;
        st_d.blink = ~st_q.blink;
      end else begin
        st_d.blink_cnt = st_q.blink_cnt + 16'h0001;
      end
    end
    if (reg_rd) begin
      st_d.rdata = rd_val;
    end

    if (reg_wr) begin
      w1c = reg_wdata;
      if (reg_addr < gwel_pkg::OFS_DATA) begin
        st_d.cfg[reg_addr[5:0]] = reg_wdata;
      end else if (reg_addr < gwel_pkg::OFS_DATA + gwel_pkg::CNT_DATA) begin
        // Only bits whose pins drive take the write.
        for (int b = 0; b < 8; b++) begin
          if (!is_in[{reg_addr[2:0], 3'(b)}]) begin
            st_d.dout[{reg_addr[2:0], 3'(b)}] = reg_wdata[b];
          end
        end
      end else if (reg_addr >= gwel_pkg::OFS_WAKE_EN &&
                   reg_addr < gwel_pkg::OFS_WAKE_EN + gwel_pkg::CNT_WAKE) begin
        st_d.wake_en[3'(reg_addr - gwel_pkg::OFS_WAKE_EN)] = reg_wdata;
      end else if (reg_addr == gwel_pkg::OFS_GWAKE) begin
        st_d.gwake = reg_wdata;
      end else if (reg_addr == gwel_pkg::OFS_LED_ONE) begin
        st_d.led[0] = reg_wdata;
      end else if (reg_addr == gwel_pkg::OFS_LED_TWO) begin
        st_d.led[1] = reg_wdata;
      end else if (reg_addr >= gwel_pkg::OFS_SMI_EN &&
                   reg_addr < gwel_pkg::OFS_SMI_EN + gwel_pkg::CNT_SMI) begin
        // Bank four bit seven is left to software to keep clear.
        st_d.smi_en[3'(reg_addr - gwel_pkg::OFS_SMI_EN)] = reg_wdata;
      end
    end

    // Wake banks: a new event wins over a one written in the same cycle.
    for (int b = 0; b < gwel_pkg::WAKE_BANKS; b++) begin
      for (int j = 0; j < 8; j++) begin
        src = gwel_pkg::WAKE_SRC[b][j];
        set_b = !src[gwel_pkg::SRC_NONE_BIT] && ev[src[5:0]];
        q_b = src[gwel_pkg::SRC_NONE_BIT] || qual[src[5:0]];
        bank = 3'(reg_addr - gwel_pkg::OFS_WAKE_STS);
        if (reg_wr && reg_addr >= gwel_pkg::OFS_WAKE_STS &&
            reg_addr < gwel_pkg::OFS_WAKE_STS + gwel_pkg::CNT_WAKE && bank == 3'(b) &&
            w1c[j]) begin
          st_d.wake_sts[b][j] = 1'b0;
        end
        if (set_b) begin
          st_d.wake_sts[b][j] = 1'b1;
        end
        wake_any = wake_any | (st_q.wake_sts[b][j] & st_q.wake_en[b][j] & q_b);
      end
    end

    // SMI banks, with the shared bank also fed by group one.
    for (int b = 0; b < gwel_pkg::SMI_BANKS; b++) begin
      for (int j = 0; j < 8; j++) begin
        src = gwel_pkg::SMI_SRC[b][j];
        set_b = !src[gwel_pkg::SRC_NONE_BIT] && ev[src[5:0]];
        q_b = src[gwel_pkg::SRC_NONE_BIT] || qual[src[5:0]];
        if (b == gwel_pkg::SMI_SHARED_BANK) begin
          set_b = set_b | ev[j];
        end
        bank = 3'(reg_addr - gwel_pkg::OFS_SMI_STS);
        if (reg_wr && reg_addr >= gwel_pkg::OFS_SMI_STS &&
            reg_addr < gwel_pkg::OFS_SMI_STS + gwel_pkg::CNT_SMI && bank == 3'(b) &&
            w1c[j]) begin
          st_d.smi_sts[b][j] = 1'b0;
        end
        if (set_b) begin
          st_d.smi_sts[b][j] = 1'b1;
        end
        smi_any = smi_any | (st_q.smi_sts[b][j] & st_q.smi_en[b][j] & q_b);
      end
    end

    // Misc status sees every transition regardless of mode.
    for (int k = 0; k < gwel_pkg::EE_PINS; k++) begin
      if (reg_wr && reg_addr == gwel_pkg::OFS_MISC && w1c[k]) begin
        st_d.misc_sts[k] = 1'b0;
      end
      if (rise[gwel_pkg::EE_PIN[k][5:0]] || fall[gwel_pkg::EE_PIN[k][5:0]]) begin
        st_d.misc_sts[k] = 1'b1;
      end
    end

    st_d.wake = wake_any & st_q.gwake[gwel_pkg::GWAKE_BIT];
    st_d.smi = smi_any;

    // Main-power and bus resets restore the special pins only; standby state is kept.
    if (main_rst || bus_rst) begin
      st_d.cfg[gwel_pkg::PIN_G3P3[5:0]] = gwel_pkg::CFG_RST_OUT;
      st_d.dout[gwel_pkg::PIN_G3P3[5:0]] = 1'b0;
      st_d.cfg[gwel_pkg::PIN_G5P3[5:0]] = gwel_pkg::CFG_RST_OUT;
      st_d.dout[gwel_pkg::PIN_G5P3[5:0]] = 1'b0;
      st_d.cfg[gwel_pkg::PIN_G4P3[5:0]][gwel_pkg::CFG_EE] = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '0;
      for (int i = 0; i < gwel_pkg::NUM_PINS; i++) begin
        st_q.cfg[i] <= (7'(i) == gwel_pkg::PIN_G3P3 || 7'(i) == gwel_pkg::PIN_G5P3)
                       ? gwel_pkg::CFG_RST_OUT : gwel_pkg::CFG_RST_IN;
      end
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata  = st_q.rdata;
  assign wake_event = st_q.wake;
  assign smi_event  = st_q.smi;
endmodule

// ==== dv/gwel_gpio_checker.sv ====
// Port checker for the general pin, wake event and LED block.
// Assumes it is bound to gwel_gpio; LED one is mirrored from host writes.
module gwel_gpio_checker #(
  parameter int BLINK_HALF = 4
) (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        main_rst,
  input wire logic        bus_rst,
  input wire logic        main_pwr_ok,
  input wire logic        clk32_in,
  input wire logic [6:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic [63:0] pin_in,
  input wire logic [63:0] pin_out,
  input wire logic [63:0] pin_oe,
  input wire logic        wake_event,
  input wire logic        smi_event
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] pin_q;
  logic [3:0]  age_q;
  logic [7:0]  led_q;
  // The age since the last pin change or host write bounds how late an event may rise.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_q <= '0;
      age_q <= 4'hf;
      led_q <= 8'h00;
    end else begin
      pin_q <= pin_in;
      age_q <= (pin_in != pin_q || reg_wr) ? 4'h0 : age_q + {3'h0, age_q != 4'hf};
      if (reg_wr && reg_addr == gwel_pkg::OFS_LED_ONE) led_q <= reg_wdata;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence clk32_still_s;
    (!reg_wr && $stable(clk32_in)) [*5];
  endsequence
  sequence pwr_gone_s;
    !main_pwr_ok [*2];
  endsequence
  pwr_rst_a: assert property (
    (main_rst || bus_rst) |=> pin_oe[19] && !pin_out[19] && pin_oe[35] && !pin_out[35])
    else $error("fan or infrared pin not low after reset");
  fan_nopwr_a: assert property (
    pwr_gone_s |-> pin_oe[19])
    else $error("fan pin not driven without main power");
  irtx_low_a: assert property (
    pwr_gone_s |-> pin_oe[35] && !pin_out[35])
    else $error("infrared pin not low without main power");
  led_on_a: assert property (
    (led_q[7] && !led_q[1] && led_q[0]) |-> pin_oe[40])
    else $error("LED one not driven while on");
  led_frozen_a: assert property (
    (led_q[7] && led_q[1]) ##0 clk32_still_s |=> $stable(pin_out[40]) && $stable(pin_oe[40]))
    else $error("LED one blinked with slow clock still");
  wake_rise_a: assert property (
    $rose(wake_event) |-> age_q <= 4'h6)
    else $error("wake event rose without a cause");
  wake_fall_a: assert property (
    $fell(wake_event) |-> $past(reg_wr, 2))
    else $error("wake event fell without a host write");
  smi_rise_a: assert property (
    $rose(smi_event) |-> age_q <= 4'h6)
    else $error("smi event rose without a cause");
  smi_fall_a: assert property (
    $fell(smi_event) |-> $past(reg_wr, 2))
    else $error("smi event fell without a host write");
endmodule

bind gwel_gpio gwel_gpio_checker #(.BLINK_HALF(BLINK_HALF)) u_chk (
  .mclk(mclk), .sys_rst(sys_rst), .main_rst(main_rst), .bus_rst(bus_rst),
  .main_pwr_ok(main_pwr_ok), .clk32_in(clk32_in), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe(pin_oe), .wake_event(wake_event), .smi_event(smi_event));

// ==== dv/gwel_board.sv ====
// Board model: pin levels, LED loads and the slow clock source.
// Assumes the bench sets board levels and starts or stops the slow clock.
module gwel_board (
  input  wire logic        mclk,
  input  wire logic        clk32_run,
  input  wire logic [63:0] ext_lvl,
  input  wire logic [63:0] pin_out,
  input  wire logic [63:0] pin_oe,
  output logic      [63:0] pin_in,
  output logic             clk32_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] div_q = 4'h0;
  // A driven pin reads back its driven level, so an open-drain sink pulls it low.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
  // The slow clock stands still while stopped, as when no crystal is fitted.
  initial clk32_in = 1'b0;
  always @(posedge mclk) begin
    if (clk32_run) begin
      div_q <= div_q + 4'h1;
      if (div_q == 4'hf) clk32_in <= ~clk32_in;
    end
  end
endmodule

// ==== dv/tb.sv ====
// Self-checking bench for the general pin, wake event and LED block.
// Assumes the board model drives the pins and the checker is bound to the design.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Fields: pin, wake status offset, wake mask, smi status offset, smi mask.
  localparam logic [39:0] TAB [0:6] = '{40'h0b_4908_6000, 40'h2a_4d10_6410,
    40'h20_4b01_6201, 40'h18_4a00_6100, 40'h19_4a10_6110, 40'h14_4d01_6401,
    40'h05_4820_6220};
  logic        mclk, sys_rst, main_rst, bus_rst, main_pwr_ok, clk32_run, clk32_in;
  logic        reg_wr, reg_rd, wake_event, smi_event;
  logic [6:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [1:0]  led_v;
  logic [63:0] ext_lvl, pin_in, pin_out, pin_oe;
  int          error_cnt = 0, checks_done = 0, cyc = 0, n;
  gwel_gpio #(.BLINK_HALF(4)) dut (.mclk(mclk), .sys_rst(sys_rst), .main_rst(main_rst),
    .bus_rst(bus_rst), .main_pwr_ok(main_pwr_ok), .clk32_in(clk32_in), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .wake_event(wake_event),
    .smi_event(smi_event));
  gwel_board brd (.mclk(mclk), .clk32_run(clk32_run), .ext_lvl(ext_lvl), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_in(pin_in), .clk32_in(clk32_in));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic waitc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge mclk) #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    waitc(1);
    reg_wr = 1'b0;
  endtask
  task automatic rdc(input logic [6:0] a, input logic [7:0] e);
    @(posedge mclk) #1;
    reg_addr = a;
    reg_rd = 1'b1;
    waitc(1);
    reg_rd = 1'b0;
    chk(reg_rdata, e);
  endtask
  task automatic blinks(input int k, output int c);
    c = 0;
    led_v = {pin_oe[40], pin_out[40]};
    repeat (k) begin
      waitc(1);
      if ({pin_oe[40], pin_out[40]} !== led_v) c++;
      led_v = {pin_oe[40], pin_out[40]};
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // The whole run needs about 1200 cycles, so this ceiling only catches a hang.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end
  initial begin
    // Order: sys_rst, main_rst, bus_rst, main_pwr_ok, clk32_run, reg_wr, reg_rd.
    {sys_rst, main_rst, bus_rst, main_pwr_ok, clk32_run, reg_wr, reg_rd} = 7'h48;
    {reg_addr, reg_wdata} = 15'h0000;
    ext_lvl = '0;
    waitc(8);
    sys_rst = 1'b0;
    rdc(7'h00, 8'h01);
    rdc(7'h13, 8'h00);
    rdc(7'h23, 8'h00);
    rdc(7'h5d, 8'h00);
    rdc(7'h7f, 8'h00);
    chk({pin_oe[35], pin_out[35], pin_oe[19], pin_out[19]}, 4'ha);
    $display("test reset done");
    ext_lvl = 64'ha5;
    waitc(4);
    rdc(7'h40, 8'ha5);
    wr(7'h00, 8'h03);
    rdc(7'h40, 8'ha4);
    wr(7'h40, 8'h5a);
    rdc(7'h40, 8'ha4);
    chk(pin_oe[7:0], 8'h00);
    wr(7'h01, 8'h00);
    rdc(7'h40, 8'ha4);
    wr(7'h40, 8'h02);
    rdc(7'h40, 8'ha6);
    chk({pin_oe[1], pin_out[1]}, 2'h3);
    wr(7'h01, 8'h02);
    chk({pin_oe[1], pin_out[1]}, 2'h2);
    rdc(7'h40, 8'ha6);
    wr(7'h00, 8'h01);
    wr(7'h01, 8'h01);
    ext_lvl = '0;
    $display("test data done");
    for (n = 0; n < 6; n++) begin
      wr(7'h48 + 7'(n), 8'hff);
      wr(7'h60 + 7'(n), 8'hff);
    end
    wr(7'h59, 8'hff);
    for (n = 0; n < 7; n++) begin
      ext_lvl[TAB[n][38:32]] = 1'b1;
      waitc(6);
      rdc(TAB[n][30:24], TAB[n][23:16]);
      rdc(TAB[n][14:8], TAB[n][7:0]);
      ext_lvl = '0;
      wr(TAB[n][30:24], 8'hff);
      wr(TAB[n][14:8], 8'hff);
    end
    $display("test map done");
    // The group-4 either-edge pin in the map pass left its misc bit set.
    wr(7'h59, 8'hff);
    ext_lvl[3] = 1'b1;
    waitc(6);
    chk(wake_event, 1'b0);
    wr(7'h50, 8'h08);
    waitc(2);
    chk(wake_event, 1'b0);
    wr(7'h58, 8'h01);
    waitc(2);
    chk(wake_event, 1'b1);
    wr(7'h48, 8'hf7);
    rdc(7'h48, 8'h08);
    wr(7'h48, 8'h08);
    waitc(2);
    chk(wake_event, 1'b0);
    wr(7'h03, 8'h03);
    ext_lvl[3] = 1'b0;
    waitc(6);
    chk(wake_event, 1'b1);
    wr(7'h48, 8'h08);
    wr(7'h50, 8'h00);
    $display("test wake done");
    wr(7'h28, 8'h06);
    chk(pin_oe[40], 1'b0);
    wr(7'h68, 8'h08);
    for (n = 0; n < 2; n++) begin
      ext_lvl[40] = ~ext_lvl[40];
      waitc(6);
      rdc(7'h59, 8'h10);
      rdc(7'h4a, 8'h40);
      chk(smi_event, 1'b1);
      rdc(7'h45, {7'h00, ~ext_lvl[40]});
      wr(7'h59, 8'h10);
      wr(7'h4a, 8'h40);
      wr(7'h60, 8'h08);
    end
    waitc(2);
    chk(smi_event, 1'b0);
    wr(7'h68, 8'h00);
    $display("test either edge done");
    wr(7'h28, 8'h00);
    wr(7'h29, 8'h80);
    wr(7'h5e, 8'h81);
    chk({pin_oe[41], pin_out[41]}, 2'h2);
    wr(7'h5d, 8'h81);
    chk({pin_oe[40], pin_out[40]}, 2'h3);
    wr(7'h5d, 8'h82);
    clk32_run = 1'b1;
    blinks(600, n);
    chk(n > 2, 1'b1);
    clk32_run = 1'b0;
    waitc(8);
    blinks(300, n);
    chk(n, 0);
    // LED edges set the group-6 pin 0 SMI status, but the pin is not in either-edge mode.
    wr(7'h68, 8'h08);
    waitc(2);
    chk(smi_event, 1'b0);
    wr(7'h68, 8'h00);
    $display("test led done");
    wr(7'h13, 8'h02);
    wr(7'h42, 8'h08);
    wr(7'h44, 8'h08);
    chk({pin_out[19], pin_out[35]}, 2'h1);
    main_pwr_ok = 1'b0;
    waitc(2);
    chk({pin_oe[19], pin_out[19], pin_oe[35], pin_out[35], pin_oe[41]}, 5'h1d);
    main_pwr_ok = 1'b1;
    main_rst = 1'b1;
    waitc(1);
    main_rst = 1'b0;
    rdc(7'h13, 8'h00);
    chk({pin_oe[35], pin_out[35]}, 2'h2);
    wr(7'h1b, 8'h04);
    bus_rst = 1'b1;
    waitc(1);
    bus_rst = 1'b0;
    rdc(7'h1b, 8'h00);
    wr(7'h5e, 8'h80);
    chk({pin_oe[41], pin_out[41]}, 2'h0);
    wr(7'h30, 8'h80);
    chk({pin_oe[48], pin_out[48]}, 2'h2);
    wr(7'h46, 8'h01);
    chk({pin_oe[48], pin_out[48]}, 2'h0);
    $display("test power done");
    stop_test();
  end
endmodule
